// File: simd_alu_map.vh
// Function
// - test_and_op Flag_setting_and first operand with flexible operand; flags only, no write.
// - test_xor_op XORs first operand with flexible operand; flags only, result dropped.
// - neither test operation writes a register; only flags change.
// - test operations set negative and zero from the 32-bit result.
// - test operations take carry only from the operand shifter carry.
// - test operations leave overflow unchanged.
// - after test_xor_op negative equals xor of both operand sign bits.
// - an operation whose condition fails writes no result or flags; illegal_reg_ff still reports sp or pc.
// - packed_uhalf_add adds two 16-bit lanes into matching destination lanes.
// - packed_ubyte_add adds four 8-bit lanes into matching destination bytes.
// - uexch_add_sub: low = a.lo - b.hi, high = a.hi + b.lo.
// - uexch_sub_add: low = a.lo + b.hi, high = a.hi - b.lo.
// - packed and exchange add/sub leave all flags unchanged.
// - halving_uhalf_add adds 16-bit lanes, halves each sum.
// - halving_ubyte_add adds 8-bit lanes, halves each sum.
// - halving_uexch_add_sub: high=(a.hi+b.lo)/2, low=(a.lo-b.hi)/2.
// - halving_uexch_sub_add: high=(a.hi-b.lo)/2, low=(a.lo+b.hi)/2.
// - halving exchange results shift right one bit; flags unchanged.
// - halving_uhalf_sub subtracts 16-bit lanes, halves each difference.
// - halving_ubyte_sub subtracts 8-bit lanes, halves each difference.
`ifndef SIMD_ALU_MAP_VH
`define SIMD_ALU_MAP_VH
// ----------------------------------------
// operation codes
// ----------------------------------------
`define OP_TEST_AND 4'h0
`define OP_TEST_XOR 4'h1
`define OP_PACKED_UHALF_ADD 4'h2
`define OP_PACKED_UBYTE_ADD 4'h3
`define OP_UEXCH_ADD_SUB 4'h4
`define OP_UEXCH_SUB_ADD 4'h5
`define OP_HALVING_UHALF_ADD 4'h6
`define OP_HALVING_UBYTE_ADD 4'h7
`define OP_HALVING_UEXCH_ADD_SUB 4'h8
`define OP_HALVING_UEXCH_SUB_ADD 4'h9
`define OP_HALVING_UHALF_SUB 4'ha
`define OP_HALVING_UBYTE_SUB 4'hb
// ----------------------------------------
// condition codes
// ----------------------------------------
`define CC_EQ 4'h0
`define CC_NE 4'h1
`define CC_CS 4'h2
`define CC_CC 4'h3
`define CC_MI 4'h4
`define CC_PL 4'h5
`define CC_VS 4'h6
`define CC_VC 4'h7
`define CC_HI 4'h8
`define CC_LS 4'h9
`define CC_GE 4'ha
`define CC_LT 4'hb
`define CC_GT 4'hc
`define CC_LE 4'hd
`define CC_AL 4'he
// ----------------------------------------
// flag positions in {n,z,c,v}
// ----------------------------------------
`define FLAG_N 3
`define FLAG_Z 2
`define FLAG_C 1
`define FLAG_V 0
`define FLAGS_RESET 4'h0
`define REG_SP 4'hd
`define REG_PC 4'hf
`endif

// File: simd_unsigned_add_sub_test_alu.v
`timescale 1ns/1ps
`include "simd_alu_map.vh"
module simd_unsigned_add_sub_test_alu #(
  parameter WIDTH = 32
) (
  input wire core_clk,
  input wire rst_n,
  input wire issue_valid,
  input wire [3:0] op_code,
  input wire [3:0] cond_code,
  input wire dest_given,
  input wire [3:0] dest_reg,
  input wire [3:0] first_operand_reg,
  input wire [WIDTH-1:0] first_operand,
  input wire [WIDTH-1:0] flexible_second_operand,
  input wire shifter_carry,
  input wire shifter_carry_valid,
  output reg [WIDTH-1:0] result_ff,
  output reg [3:0] result_reg_ff,
  output reg result_write_ff,
  output reg [3:0] program_status_flags_ff,
  output reg flags_write_ff,
  output reg illegal_reg_ff
);

  // ----------------------------------------
  // condition evaluation
  // ----------------------------------------
  function cond_pass;
    input [3:0] cc;
    input [3:0] f;
    reg n, z, c, v;
    begin
      n = f[`FLAG_N];
      z = f[`FLAG_Z];
      c = f[`FLAG_C];
      v = f[`FLAG_V];
      case (cc)
        `CC_EQ: cond_pass = z;
        `CC_NE: cond_pass = ~z;
        `CC_CS: cond_pass = c;
        `CC_CC: cond_pass = ~c;
        `CC_MI: cond_pass = n;
        `CC_PL: cond_pass = ~n;
        `CC_VS: cond_pass = v;
        `CC_VC: cond_pass = ~v;
        `CC_HI: cond_pass = c & ~z;
        `CC_LS: cond_pass = ~c | z;
        `CC_GE: cond_pass = (n == v);
        `CC_LT: cond_pass = (n != v);
        `CC_GT: cond_pass = ~z & (n == v);
        `CC_LE: cond_pass = z | (n != v);
        default: cond_pass = 1'b1;
      endcase
    end
  endfunction

  // sp or pc is unpredictable; flagged, and the write is suppressed
  function is_banned;
    input [3:0] r;
    begin
      is_banned = (r == `REG_SP) || (r == `REG_PC);
    end
  endfunction

  // ----------------------------------------
  // lane arithmetic
  // ----------------------------------------
  wire [WIDTH-1:0] a = first_operand;
  wire [WIDTH-1:0] b = flexible_second_operand;
  wire [WIDTH-1:0] b_swap = {b[15:0], b[31:16]};
  wire [WIDTH-1:0] byte_sum;
  wire [WIDTH-1:0] byte_hsum;
  wire [WIDTH-1:0] byte_hdiff;
  wire [16:0] hs_lo_sum;
  wire [16:0] hs_hi_sum;
  wire [16:0] hs_lo_dif;
  wire [16:0] hs_hi_dif;
  wire [16:0] hx_lo_sum;
  wire [16:0] hx_hi_sum;
  wire [16:0] hx_lo_dif;
  wire [16:0] hx_hi_dif;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_byte
      wire [8:0] s9 = {1'b0, a[8*gi+7:8*gi]} + {1'b0, b[8*gi+7:8*gi]};
      wire [8:0] d9 = {1'b0, a[8*gi+7:8*gi]} - {1'b0, b[8*gi+7:8*gi]};
      assign byte_sum[8*gi+7:8*gi] = s9[7:0];
      assign byte_hsum[8*gi+7:8*gi] = s9[8:1];
      assign byte_hdiff[8*gi+7:8*gi] = d9[8:1];
    end
  endgenerate

  // straight lanes (a.lo with b.lo, a.hi with b.hi)
  assign hs_lo_sum = {1'b0, a[15:0]} + {1'b0, b[15:0]};
  assign hs_hi_sum = {1'b0, a[31:16]} + {1'b0, b[31:16]};
  assign hs_lo_dif = {1'b0, a[15:0]} - {1'b0, b[15:0]};
  assign hs_hi_dif = {1'b0, a[31:16]} - {1'b0, b[31:16]};
  // crossed lanes (a.lo with b.hi, a.hi with b.lo)
  assign hx_lo_sum = {1'b0, a[15:0]} + {1'b0, b_swap[15:0]};
  assign hx_hi_sum = {1'b0, a[31:16]} + {1'b0, b_swap[31:16]};
  assign hx_lo_dif = {1'b0, a[15:0]} - {1'b0, b_swap[15:0]};
  assign hx_hi_dif = {1'b0, a[31:16]} - {1'b0, b_swap[31:16]};

  wire [WIDTH-1:0] and_res = a & b;
  wire [WIDTH-1:0] xor_res = a ^ b;

  // ----------------------------------------
  // operation select
  // ----------------------------------------
  reg [WIDTH-1:0] nxt_result;
  reg is_test;
  reg known_op;
  always @* begin
    nxt_result = {WIDTH{1'b0}};
    is_test = 1'b0;
    known_op = 1'b1;
    case (op_code)
      `OP_TEST_AND: begin
        nxt_result = and_res;
        is_test = 1'b1;
      end
      `OP_TEST_XOR: begin
        nxt_result = xor_res;
        is_test = 1'b1;
      end
      `OP_PACKED_UHALF_ADD: begin
        nxt_result = {hs_hi_sum[15:0], hs_lo_sum[15:0]};
      end
      `OP_PACKED_UBYTE_ADD: begin
        nxt_result = byte_sum;
      end
      `OP_UEXCH_ADD_SUB: begin
        nxt_result = {hx_hi_sum[15:0], hx_lo_dif[15:0]};
      end
      `OP_UEXCH_SUB_ADD: begin
        nxt_result = {hx_hi_dif[15:0], hx_lo_sum[15:0]};
      end
      `OP_HALVING_UHALF_ADD: begin
        nxt_result = {hs_hi_sum[16:1], hs_lo_sum[16:1]};
      end
      `OP_HALVING_UBYTE_ADD: begin
        nxt_result = byte_hsum;
      end
      `OP_HALVING_UEXCH_ADD_SUB: begin
        nxt_result = {hx_hi_sum[16:1], hx_lo_dif[16:1]};
      end
      `OP_HALVING_UEXCH_SUB_ADD: begin
        nxt_result = {hx_hi_dif[16:1], hx_lo_sum[16:1]};
      end
      `OP_HALVING_UHALF_SUB: begin
        nxt_result = {hs_hi_dif[16:1], hs_lo_dif[16:1]};
      end
      `OP_HALVING_UBYTE_SUB: begin
        nxt_result = byte_hdiff;
      end
      default: begin
        known_op = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // commit
  // ----------------------------------------
  wire [3:0] eff_dest = dest_given ? dest_reg : first_operand_reg;
  wire passed = issue_valid & known_op &
    cond_pass(cond_code, program_status_flags_ff);
  wire banned = is_banned(first_operand_reg) |
    (~is_test & is_banned(eff_dest));

  reg [3:0] nxt_flags;
  always @* begin
    nxt_flags = program_status_flags_ff;
    if (passed & is_test) begin
      nxt_flags[`FLAG_N] = nxt_result[WIDTH-1];
      nxt_flags[`FLAG_Z] = ~|nxt_result;
      if (shifter_carry_valid)
        nxt_flags[`FLAG_C] = shifter_carry;
      // overflow bit is left as it was
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      result_ff <= {WIDTH{1'b0}};
      result_reg_ff <= 4'h0;
      result_write_ff <= 1'b0;
      program_status_flags_ff <= `FLAGS_RESET;
      flags_write_ff <= 1'b0;
      illegal_reg_ff <= 1'b0;
    end else begin
      program_status_flags_ff <= nxt_flags;
      flags_write_ff <= passed & is_test;
      result_write_ff <= passed & ~is_test & ~banned;
      illegal_reg_ff <= issue_valid & known_op & banned;
      if (passed & ~is_test) begin
        result_ff <= nxt_result;
        result_reg_ff <= eff_dest;
      end
    end
  end

endmodule // simd_unsigned_add_sub_test_alu

// File: simd_alu_monitor.sv
`timescale 1ns/1ps
`include "simd_alu_map.vh"
module simd_alu_checker #(parameter WIDTH = 32) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic issue_valid,
  input wire logic [3:0] op_code,
  input wire logic [3:0] cond_code,
  input wire logic dest_given,
  input wire logic [3:0] dest_reg,
  input wire logic [3:0] first_operand_reg,
  input wire logic [WIDTH-1:0] first_operand,
  input wire logic [WIDTH-1:0] flexible_second_operand,
  input wire logic shifter_carry,
  input wire logic shifter_carry_valid,
  input wire logic [WIDTH-1:0] result_ff,
  input wire logic [3:0] result_reg_ff,
  input wire logic result_write_ff,
  input wire logic [3:0] program_status_flags_ff,
  input wire logic flags_write_ff,
  input wire logic illegal_reg_ff
);
  wire [WIDTH-1:0] a = first_operand;
  wire [WIDTH-1:0] b = flexible_second_operand;
  wire [3:0] f = program_status_flags_ff;
  // apart from one failing eq check, only always-true issues are judged; the condition table is not modelled
  wire go = issue_valid && cond_code == `CC_AL;
  wire tst = go && op_code <= `OP_TEST_XOR;
  wire pk = go && op_code inside {[4'h2:4'hb]};
  wire [3:0] dst = dest_given ? dest_reg : first_operand_reg;
  wire bad = dst inside {4'hd, 4'hf} || first_operand_reg inside {4'hd, 4'hf};
  wire [WIDTH-1:0] t_and = a & b;
  wire [31:0] add16 = {a[31:16] + b[31:16], a[15:0] + b[15:0]};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_test_no_write:
    assert property (tst |=> flags_write_ff && !result_write_ff)
    else $error("test op wrote a result");
  a_and_nz_flags:
    assert property (go && op_code == `OP_TEST_AND |=>
      f[3:2] == {$past(t_and[31]), ($past(t_and) == 0)})
    else $error("and test flags wrong");
  a_xor_sign:
    assert property (go && op_code == `OP_TEST_XOR |=>
      f[3] == ($past(a[31]) ^ $past(b[31])))
    else $error("xor test sign wrong");
  a_keep_overflow:
    assert property (tst |=> $stable(f[0]))
    else $error("test op moved overflow");
  a_carry_source:
    assert property (tst |=> f[1] == ($past(shifter_carry_valid) ?
      $past(shifter_carry) : $past(f[1])))
    else $error("carry not from shifter");
  a_cond_fail_quiet:
    assert property (issue_valid && cond_code == `CC_EQ && !f[2] |=>
      !result_write_ff && !flags_write_ff && $stable(f))
    else $error("failed condition had effect");
  a_packed_flags:
    assert property (pk |=> !flags_write_ff && $stable(f))
    else $error("packed op moved flags");
  a_uhalf_add:
    assert property (pk && !bad && op_code == `OP_PACKED_UHALF_ADD |=>
      result_write_ff && result_ff == $past(add16))
    else $error("halfword add wrong");
  a_dest_default:
    assert property (pk && !bad && !dest_given |=>
      result_reg_ff == $past(first_operand_reg))
    else $error("default destination wrong");
  a_bad_reg:
    assert property (pk && bad |=> illegal_reg_ff && !result_write_ff)
    else $error("sp or pc not refused");
  c_test: cover property (tst);
  c_bad: cover property (pk && bad);
  c_fail: cover property (issue_valid && cond_code == `CC_EQ && !f[2]);
endmodule // simd_alu_checker
bind simd_unsigned_add_sub_test_alu simd_alu_checker #(.WIDTH(WIDTH)) mon (
  .core_clk, .rst_n, .issue_valid, .op_code, .cond_code, .dest_given,
  .dest_reg, .first_operand_reg, .first_operand, .flexible_second_operand,
  .shifter_carry, .shifter_carry_valid, .result_ff, .result_reg_ff,
  .result_write_ff, .program_status_flags_ff, .flags_write_ff,
  .illegal_reg_ff);

// File: testbench.sv
`timescale 1ns/1ps
`include "simd_alu_map.vh"
module testbench;
  logic core_clk, rst_n, issue_valid, dest_given;
  logic shifter_carry, shifter_carry_valid;
  logic [3:0] op_code, cond_code, dest_reg, first_operand_reg;
  logic [31:0] first_operand, flexible_second_operand;
  wire [31:0] result_ff;
  wire [3:0] result_reg_ff, program_status_flags_ff;
  wire result_write_ff, flags_write_ff, illegal_reg_ff;
  int n_mismatch, checks_done;
  simd_unsigned_add_sub_test_alu #(.WIDTH(32)) dut (
    .core_clk, .rst_n, .issue_valid, .op_code, .cond_code, .dest_given,
    .dest_reg, .first_operand_reg, .first_operand, .flexible_second_operand,
    .shifter_carry, .shifter_carry_valid, .result_ff, .result_reg_ff,
    .result_write_ff, .program_status_flags_ff, .flags_write_ff,
    .illegal_reg_ff);
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  task chk(input logic [31:0] v, input logic [31:0] e);
    checks_done++;
    if (v !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, v, e);
    end
  endtask
  // one-cycle issue; the answer lands on the edge that takes it
  task issue(input logic [3:0] op, cc, input logic [31:0] a, b);
    @(posedge core_clk);
    issue_valid <= 1;
    op_code <= op;
    cond_code <= cc;
    first_operand <= a;
    flexible_second_operand <= b;
    @(posedge core_clk);
    issue_valid <= 0;
    #1;
  endtask
  // 17-bit lanes so halving keeps the carry or borrow bit
  function automatic logic [31:0] model(input logic [3:0] op,
                                        input logic [31:0] a, b);
    logic [16:0] t;
    logic [15:0] bh, bl;
    logic x;
    x = op == 4 || op == 5 || op == 8 || op == 9;
    bh = x ? b[15:0] : b[31:16];
    bl = x ? b[31:16] : b[15:0];
    t = (op == 5 || op == 9 || op == 10) ? a[31:16] - bh : a[31:16] + bh;
    model[31:16] = op >= 6 ? t[16:1] : t[15:0];
    t = (op == 4 || op == 8 || op == 10) ? a[15:0] - bl : a[15:0] + bl;
    model[15:0] = op >= 6 ? t[16:1] : t[15:0];
    if (op == 3 || op == 7 || op == 11) begin
      for (int i = 0; i < 4; i++) begin
        t = op == 11 ? a[8*i+:8] - b[8*i+:8] : a[8*i+:8] + b[8*i+:8];
        model[8*i+:8] = op >= 7 ? t[8:1] : t[7:0];
      end
    end
  endfunction
  task t_test;
    shifter_carry <= 1;
    shifter_carry_valid <= 1;
    issue(`OP_TEST_AND, `CC_AL, 32'h0000_00f0, 32'h0000_000f);
    chk(result_write_ff, 0);
    chk(flags_write_ff, 1);
    chk(program_status_flags_ff, 4'h6);
    shifter_carry <= 0;
    shifter_carry_valid <= 0;
    issue(`OP_TEST_XOR, `CC_AL, 32'h8000_0001, 32'h0000_0001);
    chk(program_status_flags_ff, 4'ha);
    chk(result_write_ff, 0);
    $display("test ops done");
  endtask
  task t_lanes(input logic [31:0] a, b);
    dest_given <= 1;
    dest_reg <= 4'h7;
    for (int op = 2; op <= 11; op++) begin
      issue(op[3:0], `CC_AL, a, b);
      chk(result_ff, model(op[3:0], a, b));
      chk(result_reg_ff, 7);
      chk(program_status_flags_ff, 4'ha);
    end
    $display("lane ops done");
  endtask
  task t_dest;
    dest_given <= 0;
    first_operand_reg <= 4'h2;
    issue(`OP_PACKED_UBYTE_ADD, `CC_AL, 32'h01ff_8080, 32'h0101_8081);
    chk(result_reg_ff, 2);
    chk(result_ff, 32'h0200_0001);
    $display("default dest done");
  endtask
  task t_cond;
    issue(`OP_PACKED_UHALF_ADD, `CC_EQ, 1, 1);
    chk(result_write_ff, 0);
    issue(`OP_TEST_AND, `CC_EQ, 0, 0);
    chk(program_status_flags_ff, 4'ha);
    issue(`OP_PACKED_UHALF_ADD, `CC_MI, 1, 1);
    chk(result_ff, 2);
    $display("conditions done");
  endtask
  task t_illegal;
    dest_given <= 1;
    dest_reg <= `REG_PC;
    issue(`OP_PACKED_UHALF_ADD, `CC_AL, 1, 1);
    chk(illegal_reg_ff, 1);
    chk(result_write_ff, 0);
    $display("sp pc refusal done");
  endtask
  // flags stand at n=1 z=0 c=1 v=0 here; bit k says whether code k passes
  task t_cond_all;
    logic [15:0] pass_map;
    pass_map = 16'he996;
    dest_given <= 1;
    dest_reg <= 4'h3;
    for (int cc = 0; cc < 16; cc++) begin
      issue(`OP_PACKED_UHALF_ADD, cc[3:0], 32'h0, 32'h0);
      chk(result_write_ff, pass_map[cc]);
    end
    $display("condition table done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {rst_n, issue_valid, op_code, cond_code, dest_given, dest_reg} = 0;
    {first_operand, flexible_second_operand} = 0;
    {shifter_carry, shifter_carry_valid} = 0;
    first_operand_reg = 1;
    repeat (16) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    #1;
    chk(program_status_flags_ff, 0);
    t_test;
    t_lanes(32'hfff0_0380, 32'h0011_ff90);
    t_lanes(32'h0011_ff90, 32'hfff0_0380);
    t_dest;
    t_cond;
    t_illegal;
    t_cond_all;
    complete_run;
  end
  initial begin
    #20000;
    n_mismatch++;
    complete_run;
  end
endmodule // testbench
